// file: qdec_pkg.sv
// Purpose: Shared constants and types for the quadrature decoder
// Assumes: Encoder outputs are logic-level square waves
// Notes: Counts derive from the 250 MHz system clock
package qdec_pkg;
  localparam int QDEC_CLK_MHZ = 250;
  localparam int QDEC_CPR = 500;
  localparam int QDEC_QUAD_PER_CYCLE = 4;
  localparam int QDEC_MAX_CNT_HZ = 130000;
  localparam int QDEC_SYNC_STAGES = 2;
  localparam int QDEC_POS_W = 16;
  localparam int QDEC_RATE_W = 20;
  // Rate gate of one millisecond
  localparam int QDEC_GATE_US = 1000;
  localparam int QDEC_GATE_CYC = QDEC_GATE_US * QDEC_CLK_MHZ;
  localparam logic [1:0] QDEC_ZERO_AB = 2'h0;
  typedef enum logic [2:0] {
    QDEC_S_IDLE = 3'h1,
    QDEC_S_ARMED = 3'h2,
    QDEC_S_SEEN = 3'h4
  } qdec_ref_t;
endpackage : qdec_pkg

// file: qdec_sync_if.sv
// Purpose: Carries synchronised encoder levels between modules
// Assumes: One clock domain
// Notes: Producer is the synchroniser, consumer the decoder
`timescale 1ns/100ps
interface qdec_sync_if;
  logic chan_a;
  logic chan_b;
  logic index;
  modport prod (output chan_a, output chan_b, output index);
  modport cons (input chan_a, input chan_b, input index);
endinterface : qdec_sync_if

// file: qdec_sync.sv
// Purpose: Two-flop synchroniser for the three encoder outputs
// Assumes: Encoder outputs are asynchronous to the clock
// Notes: Only the second stage is visible to other logic
`timescale 1ns/100ps
module qdec_sync
  import qdec_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic [2:0] i_raw, // Index, B, A from the encoder
  qdec_sync_if.prod sync // Synchronised levels
);
  logic [2:0] meta_q;
  logic [2:0] stab_q;

  // Two stages per input; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= 3'h0;
      stab_q <= 3'h0;
    end else begin
      meta_q <= i_raw;
      stab_q <= meta_q;
    end
  end

  assign sync.chan_a = stab_q[0];
  assign sync.chan_b = stab_q[1];
  assign sync.index = stab_q[2];
endmodule : qdec_sync

// file: qdec_top.sv
// Purpose: Quadrature decoder and position counter for a shaft encoder
// Assumes: Two channels in quadrature plus an index output
// Notes: Counts one step per edge, four per output cycle
// Notes on behaviour
// R1: Encoder gives two quadrature waves, optional index
// R2: Five hundred cycles per revolution
// R3: Second channel lags or leads by 90 degrees
// R4: Direction from which channel leads
// R5: Index pulse once per turn, one cycle
// R6: One cycle equals 360 electrical degrees
// R7: Track count rate of at least 130 kHz
// R8: Position from counted cycles
// R9: Phase measured between high pulse centres
// R10: Index phase from edge angle difference
// R11: Zero reference from index with both channels
// R12: Zero reference found once per revolution
// R13: Two-flop synchronise all encoder inputs
`timescale 1ns/100ps
module qdec_top
  import qdec_pkg::*;
#(
  parameter int POS_W = QDEC_POS_W, // Position counter width
  parameter int CPR = QDEC_CPR, // Output cycles per revolution
  parameter int GATE_CYC = QDEC_GATE_CYC // Rate gate length in clocks
) (
  input wire logic I_CLOCK, // 250 MHz system clock
  input wire logic I_RSTN, // Async reset, active low
  input wire logic I_ENC_A, // Encoder first channel
  input wire logic I_ENC_B, // Encoder second channel
  input wire logic I_ENC_INDEX, // Encoder index channel
  input wire logic I_ZERO_ON_REF, // Clear position at zero reference
  output logic [POS_W-1:0] O_POSITION, // Edge count within turn
  output logic O_DIR_CW, // High when A leads B
  output logic O_STEP, // One-cycle pulse per counted edge
  output logic O_ZERO_REF, // Pulse at zero reference state
  output logic O_REF_VALID, // Zero reference seen since reset
  output logic O_QUAD_ERR, // Sticky illegal transition flag
  output logic [QDEC_RATE_W-1:0] O_RATE // Edges per gate period
);
  localparam int EDGES_REV = CPR * QDEC_QUAD_PER_CYCLE;
  localparam logic [POS_W-1:0] POS_LAST = POS_W'(EDGES_REV - 1);
  localparam logic [31:0] GATE_LAST = 32'(GATE_CYC - 1);

  // ****************************************************
  // Input synchronisation
  // ****************************************************
  qdec_sync_if sif ();

  qdec_sync u_sync ( // [R13]
    .i_clk(I_CLOCK),
    .i_rstn(I_RSTN),
    .i_raw({I_ENC_INDEX, I_ENC_B, I_ENC_A}),
    .sync(sif)
  );

  // Returns +1, -1 or 0 step, and flags a double jump
  function automatic logic [2:0] qdec_step(input logic [1:0] prv,
                                           input logic [1:0] cur);
    logic [3:0] key;
    key = {prv, cur};
    case (key)
      4'h1, 4'h7, 4'he, 4'h8: qdec_step = 3'h1; // Up
      4'h2, 4'hb, 4'hd, 4'h4: qdec_step = 3'h2; // Down
      4'h3, 4'hc, 4'h6, 4'h9: qdec_step = 3'h4; // Illegal
      default: qdec_step = 3'h0;
    endcase
  endfunction : qdec_step

  // ****************************************************
  // Edge decode
  // ****************************************************
  logic [1:0] ab_q;
  logic [QDEC_SYNC_STAGES-1:0] warm_q; // Fills as sync stages fill
  logic primed_q;
  logic [1:0] ab_now;
  logic [2:0] stp;
  logic up;
  logic dn;

  assign ab_now = {sif.chan_b, sif.chan_a};
  assign stp = primed_q ? qdec_step(ab_q, ab_now) : 3'h0;
  // Gray order 00,01,11,10 means A leads B: up count
  // Pulse centres a quarter cycle apart: one count per edge
  assign up = stp[0]; // [R3] [R4] [R9]
  assign dn = stp[1]; // [R4]

  // Previous state of the channels; decode waits until the sync
  // stages and ab_q hold real pin levels, so no false edge after reset
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ab_q <= 2'h0;
      warm_q <= '0;
      primed_q <= 1'b0;
    end else begin
      ab_q <= ab_now;
      warm_q <= {warm_q[QDEC_SYNC_STAGES-2:0], 1'b1};
      primed_q <= warm_q[QDEC_SYNC_STAGES-1];
    end
  end

  // ****************************************************
  // Zero reference detection
  // ****************************************************
  logic zref_now;
  qdec_ref_t ref_q;
  logic zref_prev_q;
  logic zref_rise;

  // Index high while both channels low marks the reference
  // Expects zero index phase: index centred on the low-low state
  assign zref_now = sif.index && (ab_now == QDEC_ZERO_AB); // [R10] [R11]

  // Counts each reference state once, on its entry
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      zref_prev_q <= 1'b0;
      ref_q <= QDEC_S_IDLE;
    end else begin
      zref_prev_q <= zref_now;
      case (ref_q)
        QDEC_S_IDLE: begin
          if (zref_rise) ref_q <= QDEC_S_SEEN;
          else if (primed_q) ref_q <= QDEC_S_ARMED;
        end
        QDEC_S_ARMED: if (zref_now && !zref_prev_q) ref_q <= QDEC_S_SEEN;
        QDEC_S_SEEN: ref_q <= QDEC_S_SEEN; // [R12]
        default: ref_q <= QDEC_S_IDLE;
      endcase
    end
  end

  assign zref_rise = zref_now && !zref_prev_q && primed_q; // [R12]

  // ****************************************************
  // Position counter
  // ****************************************************
  logic [POS_W-1:0] pos_q;

  // Wraps within one revolution of 4*CPR edges
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pos_q <= '0;
    end else if (zref_rise && I_ZERO_ON_REF) begin
      pos_q <= '0; // [R11]
    end else if (up) begin
      pos_q <= (pos_q == POS_LAST) ? '0 : pos_q + 1'b1; // [R8] [R2] [R6]
    end else if (dn) begin
      pos_q <= (pos_q == '0) ? POS_LAST : pos_q - 1'b1; // [R8]
    end
  end

  // ****************************************************
  // Rate measurement
  // ****************************************************
  logic [31:0] gate_q;
  logic [QDEC_RATE_W-1:0] acc_q;
  logic [QDEC_RATE_W-1:0] rate_q;

  // Counts edges over a fixed gate; each edge is one quarter cycle
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      gate_q <= 32'h0000_0000;
      acc_q <= '0;
      rate_q <= '0;
    end else if (gate_q == GATE_LAST) begin
      gate_q <= 32'h0000_0000;
      rate_q <= acc_q; // [R7]
      acc_q <= (up || dn) ? QDEC_RATE_W'(1) : '0;
    end else begin
      gate_q <= gate_q + 32'h0000_0001;
      if ((up || dn) && !(&acc_q)) acc_q <= acc_q + 1'b1; // [R7]
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_POSITION <= '0;
      O_DIR_CW <= 1'b0;
      O_STEP <= 1'b0;
      O_ZERO_REF <= 1'b0;
      O_REF_VALID <= 1'b0;
      O_QUAD_ERR <= 1'b0;
      O_RATE <= '0;
    end else begin
      O_POSITION <= pos_q;
      if (up) O_DIR_CW <= 1'b1; // [R4]
      else if (dn) O_DIR_CW <= 1'b0;
      O_STEP <= up || dn;
      O_ZERO_REF <= zref_rise; // [R5] [R11]
      O_REF_VALID <= (ref_q == QDEC_S_SEEN);
      if (stp[2]) O_QUAD_ERR <= 1'b1; // [R1]
      O_RATE <= rate_q;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  a_step_pulse: assert property ( // [R8]
    @(posedge I_CLOCK) disable iff (!I_RSTN)
    (up || dn) |=> O_STEP)
    else $error("Counted edge gave no step pulse");

  a_dir_up: assert property ( // [R4]
    @(posedge I_CLOCK) disable iff (!I_RSTN)
    up |=> O_DIR_CW)
    else $error("A-leads edge not shown as clockwise");

  a_dir_down: assert property ( // [R4]
    @(posedge I_CLOCK) disable iff (!I_RSTN)
    dn |=> !O_DIR_CW)
    else $error("B-leads edge not shown as reverse");

  a_pos_up: assert property ( // [R8]
    @(posedge I_CLOCK) disable iff (!I_RSTN)
    (up && !zref_rise && pos_q != POS_LAST) |=>
      pos_q == $past(pos_q) + 1'b1)
    else $error("Position failed to increment");

  a_pos_wrap: assert property ( // [R2]
    @(posedge I_CLOCK) disable iff (!I_RSTN)
    (up && !zref_rise && pos_q == POS_LAST) |=> pos_q == '0)
    else $error("Position failed to wrap at revolution");

  a_zero_clear: assert property ( // [R11]
    @(posedge I_CLOCK) disable iff (!I_RSTN)
    (zref_rise && I_ZERO_ON_REF) |=> pos_q == '0 ##1 O_POSITION == '0)
    else $error("Zero reference did not clear position");

  a_zref_once: assert property ( // [R12]
    @(posedge I_CLOCK) disable iff (!I_RSTN)
    O_ZERO_REF |=> !O_ZERO_REF)
    else $error("Zero reference pulse longer than one cycle");

  a_ref_sticky: assert property ( // [R12]
    @(posedge I_CLOCK) disable iff (!I_RSTN)
    O_ZERO_REF |=> O_REF_VALID)
    else $error("Reference valid not set after zero reference");

  a_no_both: assert property ( // [R3]
    @(posedge I_CLOCK) disable iff (!I_RSTN)
    !(up && dn))
    else $error("Up and down in one cycle");

  a_err_hold: assert property ( // [R8]
    @(posedge I_CLOCK) disable iff (!I_RSTN)
    (stp[2] && !zref_rise) |=> pos_q == $past(pos_q) && O_QUAD_ERR)
    else $error("Illegal transition moved position or missed error");
endmodule : qdec_top

// file: qdec_enc_model.sv
// Purpose: Behavioural shaft encoder feeding the decoder
// Assumes: One step turns the shaft a quarter output cycle
// Notes: Outputs follow the shaft; the encoder has no reset
`timescale 1ns/100ps
module qdec_enc_model
  import qdec_pkg::*;
(
  input wire logic i_clk, // Step timing
  input wire logic i_step, // Turn one quarter cycle
  input wire logic i_up, // Direction of the turn
  input wire logic i_jump, // Fault: skip one state
  output logic o_a, // First channel
  output logic o_b, // Second channel
  output logic o_idx // Index channel
);
  localparam int EDGES = 4 * QDEC_CPR;
  int pos = 4;
  // Shaft angle in quarter cycles, wraps once per turn
  always @(posedge i_clk) begin
    if (i_jump) begin
      pos <= (pos + 2) % EDGES;
    end else if (i_step) begin
      pos <= i_up ? (pos + 1) % EDGES : (pos + EDGES - 1) % EDGES;
    end
  end
  // Second channel trails the first by a quarter cycle going up
  assign o_a = (pos % 4 == 1) || (pos % 4 == 2);
  assign o_b = (pos % 4 >= 2);
  // Index one cycle wide, centred on the low-low state
  assign o_idx = (pos >= EDGES - 2) || (pos <= 1);
endmodule : qdec_enc_model

// file: tb.sv
// Purpose: Self-checking bench for the quadrature decoder
// Assumes: Encoder model moves one state per step request
// Notes: Short rate gate of 100 clocks keeps the run brief
`timescale 1ns/100ps
module tb;
  import qdec_pkg::*;
  localparam int EDGES = 4 * QDEC_CPR;
  logic clk = 0, rstn = 0, step = 0, up = 0, jump = 0, zclr = 0;
  logic a, b, idx, dir, stp, zr, rv, qe;
  logic [QDEC_POS_W-1:0] pos;
  logic [QDEC_RATE_W-1:0] rate;
  int err_count = 0, tests_run = 0, m = 4, exp_pos = 0;
  int n_step = 0, n_zr = 0;
  qdec_top #(.GATE_CYC(100)) dut (.I_CLOCK(clk), .I_RSTN(rstn),
    .I_ENC_A(a), .I_ENC_B(b), .I_ENC_INDEX(idx), .I_ZERO_ON_REF(zclr),
    .O_POSITION(pos), .O_DIR_CW(dir), .O_STEP(stp), .O_ZERO_REF(zr),
    .O_REF_VALID(rv), .O_QUAD_ERR(qe), .O_RATE(rate));
  qdec_enc_model model (.i_clk(clk), .i_step(step), .i_up(up),
    .i_jump(jump), .o_a(a), .o_b(b), .o_idx(idx));
  // ****************************************
  // Clock, pulse counters and helpers
  // ****************************************
  initial begin
    forever #2 clk = ~clk;
  end
  // Count one-cycle pulses as they stand
  always @(posedge clk) begin
    if (stp === 1'b1) n_step++;
    if (zr === 1'b1) n_zr++;
  end
  task results;
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One shaft move, then position and, for a move without a jump, direction once settled
  task move(input logic u, input logic j);
    @(posedge clk);
    step <= ~j;
    up <= u;
    jump <= j;
    @(posedge clk);
    step <= 1'b0;
    jump <= 1'b0;
    repeat (5) @(posedge clk);
    if (j) begin
      m = (m + 2) % EDGES;
    end else begin
      m = u ? (m + 1) % EDGES : (m + EDGES - 1) % EDGES;
      exp_pos = u ? (exp_pos + 1) % EDGES : (exp_pos + EDGES - 1) % EDGES;
      if (m == 0 && zclr) exp_pos = 0;
      chk(dir, u);
    end
    chk(pos, exp_pos);
  endtask : move
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    chk({pos, dir, rv, qe}, 0);
    chk(rate, 0);
  endtask : t_reset
  task t_up_down;
    int n0;
    n0 = n_step;
    repeat (8) move(1'b1, 1'b0);
    chk(n_step - n0, 8);
    repeat (3) move(1'b0, 1'b0);
    chk(pos, 5);
  endtask : t_up_down
  task t_turn;
    int z0;
    z0 = n_zr;
    repeat (9) move(1'b0, 1'b0);
    chk(pos, EDGES - 4);
    chk({rv, 8'(n_zr - z0)}, 9'h101);
    zclr <= 1'b1;
    repeat (EDGES) move(1'b1, 1'b0);
    chk(n_zr - z0, 2);
    chk(pos, 0);
    chk(rate >= 14 && rate <= 15, 1);
  endtask : t_turn
  task t_fault;
    move(1'b1, 1'b1);
    chk(qe, 1);
    repeat (20) @(posedge clk);
    chk(qe, 1);
  endtask : t_fault
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_up_down();
    t_turn();
    t_fault();
    results();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    results();
  end
endmodule : tb
